//--- core/aspc_fifo.sv
// Conversion word FIFO with valid/ready on both sides
`timescale 1ns/100ps
module aspc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  assign empty       = (wr_ptr == rd_ptr);
  assign full        = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
    end else if (in_valid_i && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rd_ptr <= '0;
    end else if (out_ready_i && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // aspc_fifo

//--- core/aspc_port.sv
// Serial port control of the sigma-delta converter: clocking, framing, registers
`timescale 1ns/100ps
module aspc_port
  import aspc_pkg::*;
#(
  parameter int WORD  = WORD_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  input  wire logic            mode_i,
  input  wire logic            receive_frame_strobe_n_i,
  input  wire logic            transmit_frame_strobe_n_i,
  input  wire logic            register_select_i,
  input  wire logic            filter_sync_n_i,
  input  wire logic            sclk_i,
  output logic                 sclk_o,
  output logic                 sclk_oe_o,
  input  wire logic            sdata_i,
  output logic                 sdata_o,
  output logic                 sdata_oe_o,
  output logic                 data_ready_n_o,
  input  wire logic            conv_valid_i,
  output logic                 conv_ready_o,
  input  wire logic [WORD-1:0] conv_data_i,
  output logic      [WORD-1:0] ctrl_word_o,
  output logic      [WORD-1:0] cal_word_o,
  output logic                 burnout_en_o,
  output logic                 filter_reset_o
);
  localparam int CW = $clog2(WORD + 1);
  localparam int DW = $clog2(SCLK_HALF_CYC + 1);

  logic [S_WIDTH-1:0] sync1;
  logic [S_WIDTH-1:0] sync2;
  logic               sclk_q;
  aspc_state_t        state;
  logic [WORD-1:0]    shreg;
  logic [CW-1:0]      bitcnt;
  logic [DW-1:0]      div;
  logic               self_clk;
  logic               rfs_n;
  logic               tfs_n;
  logic               fall_ev;
  logic               rise_ev;
  logic               in_frame;
  logic               last_bit;
  logic               fifo_valid;
  logic               fifo_pop;
  logic [WORD-1:0]    fifo_data;
  aspc_tgt_t          tgt;

  // Routing of an access by select pin and calibration-access bit
  function automatic aspc_tgt_t route(input logic sel, input logic cal);
    if (!sel) begin
      route = ASPC_TGT_CTRL;
    end else if (cal) begin
      route = ASPC_TGT_CAL;
    end else begin
      route = ASPC_TGT_DATA;
    end
  endfunction

  // All pins are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
    end else begin
      sync1 <= {sdata_i, sclk_i, filter_sync_n_i, register_select_i,
                transmit_frame_strobe_n_i, receive_frame_strobe_n_i, mode_i};
      sync2 <= sync1;
    end
  end

  assign self_clk = sync2[S_MODE];
  assign rfs_n    = sync2[S_RFS];
  assign tfs_n    = sync2[S_TFS];
  assign tgt      = route(sync2[S_SEL], ctrl_word_o[CTRL_CAL_SEL_BIT]);
  assign in_frame = (state == ASPC_READ) || (state == ASPC_WRITE);
  assign last_bit = (bitcnt == CW'(WORD - 1));

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sync2[S_SCLK];
    end
  end

  // Edge source: own divider in self-clocking, sampled host clock otherwise
  always_comb begin
    if (self_clk) begin
      fall_ev = in_frame && (div == '0) && sclk_o;
      rise_ev = in_frame && (div == '0) && !sclk_o;
    end else begin
      fall_ev = in_frame && sclk_q && !sync2[S_SCLK];
      rise_ev = in_frame && !sclk_q && sync2[S_SCLK];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !in_frame || !self_clk || div == '0) begin
      div <= DW'(SCLK_HALF_CYC - 1);
    end else begin
      div <= div - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !in_frame || !self_clk) begin
      sclk_o <= 1'b1;
    end else if (fall_ev) begin
      sclk_o <= 1'b0;
    end else if (rise_ev) begin
      sclk_o <= 1'b1;
    end
  end

  assign sclk_oe_o = self_clk && in_frame;

  // Frame sequencing; a strobe going high aborts the word at once
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ASPC_IDLE;
    end else begin
      unique case (state)
        ASPC_IDLE: begin
          if (!rfs_n) begin
            state <= ASPC_READ;
          end else if (!tfs_n) begin
            state <= ASPC_WRITE;
          end
        end
        ASPC_READ: begin
          if (rfs_n || (rise_ev && last_bit)) begin
            state <= rfs_n ? ASPC_IDLE : ASPC_DONE;
          end
        end
        ASPC_WRITE: begin
          if (tfs_n || (rise_ev && last_bit)) begin
            state <= tfs_n ? ASPC_IDLE : ASPC_DONE;
          end
        end
        ASPC_DONE: begin
          if (rfs_n && tfs_n) begin
            state <= ASPC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !in_frame) begin
      bitcnt <= '0;
    end else if (rise_ev) begin
      bitcnt <= bitcnt + 1'b1;
    end
  end

  // Read words load at frame start; data register pops the FIFO head
  assign fifo_pop = (state == ASPC_IDLE) && !rfs_n && (tgt == ASPC_TGT_DATA);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      shreg <= '0;
    end else if (state == ASPC_IDLE && !rfs_n) begin
      unique case (tgt)
        ASPC_TGT_CTRL: shreg <= ctrl_word_o;
        ASPC_TGT_CAL:  shreg <= cal_word_o;
        ASPC_TGT_DATA: shreg <= fifo_valid ? fifo_data : '0;
      endcase
    end else if (state == ASPC_READ && fall_ev && bitcnt != '0) begin
      shreg <= {shreg[WORD-2:0], 1'b0};
    end else if (state == ASPC_WRITE && rise_ev) begin
      shreg <= {shreg[WORD-2:0], sync2[S_SDATA]};
    end
  end

  assign sdata_o    = shreg[WORD-1];
  assign sdata_oe_o = (state == ASPC_READ);

  // Written words commit only when all bits have arrived
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_word_o <= CTRL_RESET;
    end else if (state == ASPC_WRITE && !tfs_n && rise_ev && last_bit
                 && tgt == ASPC_TGT_CTRL) begin
      ctrl_word_o <= {shreg[WORD-2:0], sync2[S_SDATA]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cal_word_o <= CAL_RESET;
    end else if (state == ASPC_WRITE && !tfs_n && rise_ev && last_bit
                 && tgt == ASPC_TGT_CAL) begin
      cal_word_o <= {shreg[WORD-2:0], sync2[S_SDATA]};
    end
  end

  assign burnout_en_o = ctrl_word_o[CTRL_BURNOUT_BIT];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      filter_reset_o <= 1'b0;
    end else begin
      filter_reset_o <= !sync2[S_FSYNC];
    end
  end

  assign data_ready_n_o = !fifo_valid;

  aspc_fifo #(
    .WIDTH (WORD),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (conv_valid_i),
    .in_ready_o  (conv_ready_o),
    .in_data_i   (conv_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  a_sclk_mode_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sclk_oe_o |-> self_clk) else $error("serial clock driven in external mode");

  a_sclk_frame_start: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == ASPC_IDLE && self_clk && !rfs_n) |=> sclk_oe_o)
    else $error("serial clock not driven after read strobe");

  a_sclk_strobe_rel: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == ASPC_READ && rfs_n) |=> !sclk_oe_o)
    else $error("serial clock not released on strobe high");

  a_sclk_word_rel: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == ASPC_READ && rise_ev && last_bit) |=> !sclk_oe_o && !sdata_oe_o)
    else $error("serial clock not released after full word");

  a_ctrl_route: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == ASPC_WRITE && sync2[S_SEL]) |=> $stable(ctrl_word_o))
    else $error("control register written with select high");

  a_read_route: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == ASPC_IDLE && !rfs_n && !sync2[S_SEL]) |=> shreg == $past(ctrl_word_o))
    else $error("control read did not load control register");

  a_filter_sync: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !filter_sync_n_i ##1 !filter_sync_n_i ##1 !filter_sync_n_i |=> filter_reset_o)
    else $error("filter reset missing after sync asserted");

  a_burnout_bit: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (state == ASPC_WRITE && !tfs_n && rise_ev && last_bit && tgt == ASPC_TGT_CTRL)
    |=> burnout_en_o == $past(shreg[CTRL_BURNOUT_BIT - 1]))
    else $error("burnout source does not follow control bit");

  a_bit_count: assert property (@(posedge clk_i) disable iff (!rstn_i)
    bitcnt <= CW'(WORD)) else $error("bit counter beyond word length");
endmodule // aspc_port

//--- include/aspc_pkg.sv
// Shared constants for the converter serial port control block
package aspc_pkg;
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          WORD_BITS        = 24;
  localparam int          FIFO_DEPTH       = 32;
  // Self-clock half period, in ns, and in cycles (rounded down, at least one)
  localparam int          SCLK_HALF_NS     = 100;
  localparam int          SCLK_HALF_CYC    = (SCLK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                             (SCLK_HALF_NS / CLK_PERIOD_NS);
  localparam int          CTRL_BURNOUT_BIT = 20;
  localparam int          CTRL_CAL_SEL_BIT = 21;
  localparam logic [23:0] CTRL_RESET       = 24'h00_0000;
  localparam logic [23:0] CAL_RESET        = 24'h00_0000;
  // Synchroniser vector layout
  localparam int          S_MODE           = 0;
  localparam int          S_RFS            = 1;
  localparam int          S_TFS            = 2;
  localparam int          S_SEL            = 3;
  localparam int          S_FSYNC          = 4;
  localparam int          S_SCLK           = 5;
  localparam int          S_SDATA          = 6;
  localparam int          S_WIDTH          = 7;
  localparam logic [6:0]  SYNC_RESET       = 7'h7E;

  typedef enum logic [1:0] {
    ASPC_TGT_CTRL,
    ASPC_TGT_DATA,
    ASPC_TGT_CAL
  } aspc_tgt_t;

  typedef enum logic [1:0] {
    ASPC_IDLE,
    ASPC_READ,
    ASPC_WRITE,
    ASPC_DONE
  } aspc_state_t;
endpackage

//--- verification/aspc_host.sv
// Host-side serial port model: strobes, select, link clock and data
`timescale 1ns/100ps
module aspc_host (
  input  wire logic clk_i,
  input  wire logic sclk_i,
  input  wire logic sclk_oe_i,
  input  wire logic sdata_i,
  input  wire logic sdata_oe_i,
  output logic      mode_o,
  output logic      rx_strobe_n_o,
  output logic      tx_strobe_n_o,
  output logic      select_o,
  output logic      sclk_pin_o,
  output logic      sdata_pin_o
);
  logic h_sclk  = 1'b1;
  logic h_sdata = 1'b0;
  logic h_drive = 1'b0;
  logic churn   = 1'b0;
  initial begin
    mode_o        = 1'b0;
    rx_strobe_n_o = 1'b1;
    tx_strobe_n_o = 1'b1;
    select_o      = 1'b0;
  end
  // Released lines churn so a stale level never passes for data
  always @(posedge clk_i) churn <= ~churn;
  assign sclk_pin_o  = sclk_oe_i ? sclk_i : (mode_o ? churn : h_sclk);
  assign sdata_pin_o = sdata_oe_i ? sdata_i : (h_drive ? h_sdata : churn);
  // One frame; a stop below 24 aborts by raising the strobe early
  task automatic frame(input logic self, rd, sel, input logic [23:0] wd, input int stop,
                       output logic [23:0] rw, output int bits, output logic oe_after);
    logic last;
    logic pd;
    int   n;
    rw   = 24'h00_0000;
    bits = 0;
    last = 1'b1;
    pd   = 1'b0;
    n    = 0;
    @(posedge clk_i);
    #2;
    mode_o   = self;
    select_o = sel;
    h_sdata  = wd[23];
    h_drive  = !rd;
    repeat (4) @(posedge clk_i);
    #2;
    if (rd) rx_strobe_n_o = 1'b0;
    else tx_strobe_n_o = 1'b0;
    if (!self) begin
      repeat (4) @(posedge clk_i);
      #2;
      // Gated clock: a pause in mid-word
      for (int i = 0; i < stop; i++) begin
        #40 h_sclk = 1'b0;
        h_sdata = wd[23-i];
        #40 rw = {rw[22:0], sdata_pin_o};
        h_sclk = 1'b1;
        bits++;
        if (i == 11) #400;
      end
      #80;
    end else begin
      while (bits < stop && n < 1000) begin
        @(posedge clk_i);
        #2;
        n++;
        // Latch the level held just before the rise; the last rise
        // coincides with the device releasing its data line
        if (sclk_i && !last) begin
          rw = {rw[22:0], pd};
          bits++;
        end
        if (!sclk_i && last && bits < 24) h_sdata = wd[23-bits];
        last = sclk_i;
        pd   = sdata_pin_o;
      end
    end
    if (stop < 24) begin
      rx_strobe_n_o = 1'b1;
      tx_strobe_n_o = 1'b1;
    end
    repeat (5) @(posedge clk_i);
    #2;
    oe_after      = sclk_oe_i | sdata_oe_i;
    rx_strobe_n_o = 1'b1;
    tx_strobe_n_o = 1'b1;
    h_drive       = 1'b0;
    repeat (4) @(posedge clk_i);
    #2;
  endtask
endmodule // aspc_host

//--- verification/test_aspc_port.sv
// Self-checking bench for the converter serial port control block
`timescale 1ns/100ps
module test_aspc_port;
  import aspc_pkg::*;
  logic        clk_i   = 1'b0;
  logic        rstn_i  = 1'b0;
  logic        fsync_n = 1'b1;
  logic        cv      = 1'b0;
  logic [23:0] cd      = 24'h00_0000;
  logic        mode, rx_n, tx_n, sel, sclk_pin, sdata_pin, sclk_o, sclk_oe, sdata_o;
  logic        sdata_oe, dready_n, cr, burn, frst, oe_after;
  logic [23:0] ctrl, cal, rw;
  int          bits;
  int          miscompares = 0;
  int          n_tests = 0;

  // Master clock never stops outside standby
  always #5 clk_i = ~clk_i;

  aspc_port i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode),
    .receive_frame_strobe_n_i(rx_n), .transmit_frame_strobe_n_i(tx_n),
    .register_select_i(sel), .filter_sync_n_i(fsync_n), .sclk_i(sclk_pin),
    .sclk_o(sclk_o), .sclk_oe_o(sclk_oe), .sdata_i(sdata_pin), .sdata_o(sdata_o),
    .sdata_oe_o(sdata_oe), .data_ready_n_o(dready_n), .conv_valid_i(cv),
    .conv_ready_o(cr), .conv_data_i(cd), .ctrl_word_o(ctrl), .cal_word_o(cal),
    .burnout_en_o(burn), .filter_reset_o(frst));
  aspc_host i_host (.clk_i(clk_i), .sclk_i(sclk_o), .sclk_oe_i(sclk_oe),
    .sdata_i(sdata_o), .sdata_oe_i(sdata_oe), .mode_o(mode), .rx_strobe_n_o(rx_n),
    .tx_strobe_n_o(tx_n), .select_o(sel), .sclk_pin_o(sclk_pin), .sdata_pin_o(sdata_pin));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic xfer(input logic self, rd, s, input logic [23:0] wd, input int stop);
    i_host.frame(self, rd, s, wd, stop, rw, bits, oe_after);
    // A self-clocked frame that runs out of its bound has timed out
    check(24'(bits), 24'(stop));
    if (bits != stop) summarize();
  endtask

  task automatic t_sync();
    fsync_n = 1'b0;
    cyc(100);
    check(24'(frst), 24'h00_0001);
    fsync_n = 1'b1;
    cyc(5);
    check(24'(frst), 24'h00_0000);
  endtask
  task automatic t_ctrl();
    xfer(1'b0, 1'b0, 1'b0, 24'h10_0A5C, 24);
    check(ctrl, 24'h10_0A5C);
    check(24'(burn), 24'h00_0001);
    check(24'(oe_after), 24'h00_0000);
    xfer(1'b1, 1'b1, 1'b0, 24'h00_0000, 24);
    check(rw, 24'h10_0A5C);
    check(24'(bits), 24'h00_0018);
    check(24'(oe_after), 24'h00_0000);
  endtask
  task automatic t_cal();
    xfer(1'b0, 1'b0, 1'b0, 24'h20_0000, 24);
    check(24'(burn), 24'h00_0000);
    xfer(1'b1, 1'b0, 1'b1, 24'hC3_5A96, 24);
    check(cal, 24'hC3_5A96);
    xfer(1'b0, 1'b0, 1'b0, 24'h00_0000, 24);
    // Data register is read-only: this write must vanish
    xfer(1'b0, 1'b0, 1'b1, 24'h0F_F0F0, 24);
    check(cal, 24'hC3_5A96);
  endtask
  task automatic t_abort();
    xfer(1'b1, 1'b0, 1'b0, 24'hFF_FFFF, 5);
    check(24'(oe_after), 24'h00_0000);
    check(ctrl, 24'h00_0000);
  endtask
  task automatic t_self_data();
    cv = 1'b1;
    cd = 24'hA5_3C96;
    cyc(1);
    cv = 1'b0;
    cyc(2);
    check(24'(dready_n), 24'h00_0000);
    xfer(1'b1, 1'b1, 1'b1, 24'h00_0000, 24);
    check(rw, 24'hA5_3C96);
    check(24'(oe_after), 24'h00_0000);
    check(24'(dready_n), 24'h00_0001);
  endtask
  task automatic t_fifo();
    int cnt;
    cnt = 0;
    cv  = 1'b1;
    while (cr && cnt < 40) begin
      cd = 24'h5A_0000 + 24'(cnt);
      cyc(1);
      cnt++;
    end
    cv = 1'b0;
    check(24'(cnt), 24'(FIFO_DEPTH));
    // Host drains slowly with idle gaps between frames
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      xfer(1'b0, 1'b1, 1'b1, 24'h00_0000, 24);
      check(rw, 24'h5A_0000 + 24'(i));
    end
    check(24'(dready_n), 24'h00_0001);
    xfer(1'b0, 1'b1, 1'b1, 24'h00_0000, 24);
    check(rw, 24'h00_0000);
  endtask

  initial begin
    cyc(12);
    rstn_i = 1'b1;
    check({sclk_o, sclk_oe, sdata_oe, burn, frst, dready_n, cr}, 24'h00_0043);
    check(ctrl, CTRL_RESET);
    check(cal, CAL_RESET);
    t_sync();
    t_ctrl();
    t_cal();
    t_abort();
    t_self_data();
    t_fifo();
    summarize();
  end
endmodule // test_aspc_port
